/* File: hw/ata_multiple_sleep_smart_cmds.sv */
// Contract
// - Opcode c6 is decoded as the command that sets the multi-sector block size.
// - The block size is the number of sectors moved between interrupts in multi-sector transfers.
// - The size comes from the sector count byte and only 0, 1, 2, 4, 8 or 16 are accepted.
// - A size of zero turns multi-sector transfers off.
// - Any other size aborts the command and also turns multi-sector transfers off.
// - Opcodes e6 and 99 both put the device to sleep.
// - Entering sleep spins the media down and makes the host interface inactive.
// - If the media is already spun down, sleep is entered without a spin-down.
// - Sleep is left only by soft reset or hard reset.
// - Opcode b0 is decoded as the monitoring command.
// - Feature codes d0 to d3 select read values, read thresholds, autosave toggle and save values.
// - Feature codes d4 to d6 select offline routine, read log and write log.
// - Feature codes d8 to db select enable, disable, health status and auto offline toggle.
`timescale 1ns/1ps
`include "ata_cmd_cfg.svh"

module ata_multiple_sleep_smart_cmds #(
	parameter int BLOCK_MAX = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic soft_reset,
	input wire logic tf_wr_en,
	input wire logic [2:0] tf_sel,
	input wire logic [7:0] tf_wdata,
	input wire logic media_spun_down,
	input wire logic spin_down_done,
	input wire logic multi_xfer_active,
	input wire logic sector_done,
	input wire logic mon_done,
	input wire logic mon_fail,
	output logic [7:0] drive_status_byte,
	output logic [7:0] command_error_byte,
	output logic cmd_complete,
	output logic spin_down_req,
	output logic sleep_active,
	output logic multi_enable,
	output logic [4:0] multi_block_size,
	output logic block_boundary,
	output logic mon_start,
	output ata_cmd_pkg::mon_op_e mon_op,
	output logic [7:0] mon_count,
	output logic [7:0] mon_sector
);
	// ==========================================
	// elaboration check
	if (BLOCK_MAX < 1 || BLOCK_MAX > 16 || (BLOCK_MAX & (BLOCK_MAX - 1)) != 0) begin : g_bad_block_max
		$error("BLOCK_MAX must be a power of two from 1 to 16");
	end

	localparam logic [7:0] BLOCK_MAX_B = 8'(BLOCK_MAX);

	// ==========================================
	// task-file shadow registers
	logic [7:0] feature_q;
	logic [7:0] count_q;
	logic [7:0] sector_q;
	logic [7:0] cyl_lo_q;
	logic [7:0] cyl_hi_q;
	logic [7:0] opcode_q;
	ata_cmd_pkg::cmd_state_e state_q;
	ata_cmd_pkg::cmd_state_e state_d;

	// only idle takes task-file writes
	wire host_live = (state_q == ata_cmd_pkg::ST_IDLE);
	wire wr_ok = tf_wr_en && host_live;
	wire wr_feature = wr_ok && tf_sel == `TF_SEL_FEATURE;
	wire wr_count = wr_ok && tf_sel == `TF_SEL_COUNT;
	wire wr_sector = wr_ok && tf_sel == `TF_SEL_SECTOR;
	wire wr_cyl_lo = wr_ok && tf_sel == `TF_SEL_CYL_LO;
	wire wr_cyl_hi = wr_ok && tf_sel == `TF_SEL_CYL_HI;
	wire wr_command = wr_ok && tf_sel == `TF_SEL_COMMAND;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			feature_q <= 8'h00;
			count_q <= 8'h00;
			sector_q <= 8'h00;
			cyl_lo_q <= 8'h00;
			cyl_hi_q <= 8'h00;
			opcode_q <= 8'h00;
		end else begin
			if (wr_feature) feature_q <= tf_wdata;
			if (wr_count) count_q <= tf_wdata;
			if (wr_sector) sector_q <= tf_wdata;
			if (wr_cyl_lo) cyl_lo_q <= tf_wdata;
			if (wr_cyl_hi) cyl_hi_q <= tf_wdata;
			if (wr_command) opcode_q <= tf_wdata;
		end
	end

	// ==========================================
	// opcode decode
	wire op_multi = opcode_q == `OP_SET_MULTI;
	wire op_sleep = (opcode_q == `OP_SLEEP) || (opcode_q == `OP_SLEEP_ALT);
	wire op_mon = opcode_q == `OP_MONITOR;
	wire op_known = op_multi || op_sleep || op_mon;

	// ==========================================
	// block size check
	wire size_pow2 = (count_q == 8'h01) || (count_q == 8'h02) || (count_q == 8'h04) || (count_q == 8'h08)
		|| (count_q == 8'h10);
	wire size_zero = count_q == 8'h00;
	wire size_ok = size_zero || (size_pow2 && count_q <= BLOCK_MAX_B);
	wire size_store = size_ok && !size_zero;

	// ==========================================
	// monitoring subcommand decode
	mon_dec_if mdec ();
	assign mdec.feature = feature_q;
	assign mdec.count = count_q;
	assign mdec.sector = sector_q;
	assign mdec.cyl_lo = cyl_lo_q;
	assign mdec.cyl_hi = cyl_hi_q;

	mon_subcmd_decode u_dec (
		.bus(mdec)
	);

	// ==========================================
	// command sequencer
	wire in_exec = state_q == ata_cmd_pkg::ST_EXEC;
	wire exec_multi = in_exec && op_multi;
	wire exec_sleep = in_exec && op_sleep;
	wire exec_mon = in_exec && op_mon;
	wire exec_other = in_exec && !op_known;
	wire mon_go = exec_mon && !mdec.abort;
	wire spin_go = exec_sleep && !media_spun_down;
	wire sleep_now = exec_sleep && media_spun_down;
	wire spin_fin = (state_q == ata_cmd_pkg::ST_SPIN) && spin_down_done;
	wire mon_fin = (state_q == ata_cmd_pkg::ST_MON_WAIT) && mon_done;
	wire size_abort = exec_multi && !size_ok;
	wire mon_abort = exec_mon && mdec.abort;
	wire mon_fault = mon_fin && mon_fail;
	wire abort_now = size_abort || mon_abort || exec_other || mon_fault;
	wire done_now = exec_multi || mon_abort || exec_other || mon_fin || sleep_now || spin_fin;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ata_cmd_pkg::ST_IDLE: begin
				if (wr_command) state_d = ata_cmd_pkg::ST_EXEC;
			end
			ata_cmd_pkg::ST_EXEC: begin
				if (op_sleep) begin
					state_d = media_spun_down ? ata_cmd_pkg::ST_SLEEP : ata_cmd_pkg::ST_SPIN;
				end else if (mon_go) begin
					state_d = ata_cmd_pkg::ST_MON_WAIT;
				end else begin
					state_d = ata_cmd_pkg::ST_IDLE;
				end
			end
			ata_cmd_pkg::ST_SPIN: begin
				if (spin_down_done) state_d = ata_cmd_pkg::ST_SLEEP;
			end
			ata_cmd_pkg::ST_SLEEP: begin
				state_d = ata_cmd_pkg::ST_SLEEP;
			end
			ata_cmd_pkg::ST_MON_WAIT: begin
				if (mon_done) state_d = ata_cmd_pkg::ST_IDLE;
			end
			default: begin
				state_d = ata_cmd_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ata_cmd_pkg::ST_IDLE;
		end else if (soft_reset) begin
			state_q <= ata_cmd_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================
	// status and error bytes
	logic busy_q;
	logic err_q;
	logic abt_q;
	logic done_q;
	logic spin_req_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			err_q <= 1'b0;
			abt_q <= 1'b0;
			done_q <= 1'b0;
			spin_req_q <= 1'b0;
		end else if (soft_reset) begin
			busy_q <= 1'b0;
			err_q <= 1'b0;
			abt_q <= 1'b0;
			done_q <= 1'b0;
			spin_req_q <= 1'b0;
		end else begin
			done_q <= done_now;
			spin_req_q <= spin_go;
			if (wr_command) begin
				busy_q <= 1'b1;
				err_q <= 1'b0;
				abt_q <= 1'b0;
			end else if (done_now) begin
				busy_q <= 1'b0;
				err_q <= abort_now;
				abt_q <= abort_now;
			end
		end
	end

	always_comb begin
		drive_status_byte = `STATUS_RESET;
		drive_status_byte[`ST_BSY] = busy_q;
		drive_status_byte[`ST_RDY] = !busy_q;
		drive_status_byte[`ST_DF] = 1'b0;
		drive_status_byte[`ST_DRQ] = 1'b0;
		drive_status_byte[`ST_ERR] = err_q;
		command_error_byte = `ERROR_RESET;
		command_error_byte[`ERR_ABT] = abt_q;
	end

	assign cmd_complete = done_q;
	assign spin_down_req = spin_req_q;
	assign sleep_active = state_q == ata_cmd_pkg::ST_SLEEP;

	// ==========================================
	// multi-sector block size
	logic multi_en_q;
	logic [4:0] block_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			multi_en_q <= 1'b0;
			block_q <= 5'h00;
		end else if (exec_multi) begin
			multi_en_q <= size_store;
			block_q <= size_store ? count_q[4:0] : 5'h00;
		end
	end

	assign multi_enable = multi_en_q;
	assign multi_block_size = block_q;

	// ==========================================
	// sectors per interrupt
	logic [4:0] sec_cnt_q;
	logic boundary_q;
	wire sec_tick = multi_xfer_active && multi_en_q && sector_done;
	wire sec_last = (sec_cnt_q + 5'h01) == block_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sec_cnt_q <= 5'h00;
			boundary_q <= 1'b0;
		end else begin
			boundary_q <= sec_tick && sec_last;
			if (!multi_xfer_active) begin
				sec_cnt_q <= 5'h00;
			end else if (sec_tick) begin
				sec_cnt_q <= sec_last ? 5'h00 : sec_cnt_q + 5'h01;
			end
		end
	end

	assign block_boundary = boundary_q;

	// ==========================================
	// monitoring dispatch
	logic mon_start_q;
	ata_cmd_pkg::mon_op_e mon_op_q;
	logic [7:0] mon_count_q;
	logic [7:0] mon_sector_q;
	wire mon_launch = mon_go && !soft_reset;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mon_start_q <= 1'b0;
			mon_op_q <= ata_cmd_pkg::MON_OP_NONE;
			mon_count_q <= 8'h00;
			mon_sector_q <= 8'h00;
		end else begin
			mon_start_q <= mon_launch;
			if (mon_go) begin
				mon_op_q <= mdec.op;
				mon_count_q <= count_q;
				mon_sector_q <= sector_q;
			end
		end
	end

	assign mon_start = mon_start_q;
	assign mon_op = mon_op_q;
	assign mon_count = mon_count_q;
	assign mon_sector = mon_sector_q;
endmodule : ata_multiple_sleep_smart_cmds

/* File: hw/ata_cmd_cfg.svh */
`ifndef ATA_CMD_CFG_SVH
`define ATA_CMD_CFG_SVH

// ==========================================
// task-file register selects
`define TF_SEL_FEATURE 3'h1
`define TF_SEL_COUNT 3'h2
`define TF_SEL_SECTOR 3'h3
`define TF_SEL_CYL_LO 3'h4
`define TF_SEL_CYL_HI 3'h5
`define TF_SEL_DEVHEAD 3'h6
`define TF_SEL_COMMAND 3'h7

// ==========================================
// opcodes
`define OP_SET_MULTI 8'hc6
`define OP_SLEEP 8'he6
`define OP_SLEEP_ALT 8'h99
`define OP_MONITOR 8'hb0

// ==========================================
// monitoring key and subcommand codes
`define MON_KEY_LO 8'h4f
`define MON_KEY_HI 8'hc2
`define MON_READ_VALUES 8'hd0
`define MON_READ_THRESH 8'hd1
`define MON_AUTOSAVE 8'hd2
`define MON_SAVE_VALUES 8'hd3
`define MON_OFFLINE_NOW 8'hd4
`define MON_READ_LOG 8'hd5
`define MON_WRITE_LOG 8'hd6
`define MON_ENABLE 8'hd8
`define MON_DISABLE 8'hd9
`define MON_HEALTH 8'hda
`define MON_AUTO_OFFLINE 8'hdb
`define AUTOSAVE_OFF 8'h00
`define AUTOSAVE_ON 8'hf1
`define LOG_EXT_ERR 8'h03
`define LOG_EXT_TEST 8'h07
`define LOG_SELECTIVE 8'h09
`define LOG_VENDOR_LO 8'h80
`define LOG_VENDOR_HI 8'h9f

// ==========================================
// status and error bit positions, reset values
`define ST_BSY 7
`define ST_RDY 6
`define ST_DF 5
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ERR_ABT 2
`define STATUS_RESET 8'h50
`define ERROR_RESET 8'h00

`endif

/* File: hw/ata_cmd_pkg.sv */
package ata_cmd_pkg;

	typedef enum logic [3:0] {
		MON_OP_NONE = 4'h0,
		MON_OP_READ_VALUES = 4'h1,
		MON_OP_READ_THRESH = 4'h2,
		MON_OP_AUTOSAVE = 4'h3,
		MON_OP_SAVE_VALUES = 4'h4,
		MON_OP_OFFLINE_NOW = 4'h5,
		MON_OP_READ_LOG = 4'h6,
		MON_OP_WRITE_LOG = 4'h7,
		MON_OP_ENABLE = 4'h8,
		MON_OP_DISABLE = 4'h9,
		MON_OP_HEALTH = 4'ha,
		MON_OP_AUTO_OFFLINE = 4'hb
	} mon_op_e;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_EXEC = 5'b00010,
		ST_SPIN = 5'b00100,
		ST_SLEEP = 5'b01000,
		ST_MON_WAIT = 5'b10000
	} cmd_state_e;

endpackage : ata_cmd_pkg

/* File: hw/mon_dec_if.sv */
`timescale 1ns/1ps
interface mon_dec_if;
	logic [7:0] feature;
	logic [7:0] count;
	logic [7:0] sector;
	logic [7:0] cyl_lo;
	logic [7:0] cyl_hi;
	ata_cmd_pkg::mon_op_e op;
	logic abort;

	modport dec (
		input feature,
		input count,
		input sector,
		input cyl_lo,
		input cyl_hi,
		output op,
		output abort
	);

	modport user (
		output feature,
		output count,
		output sector,
		output cyl_lo,
		output cyl_hi,
		input op,
		input abort
	);
endinterface : mon_dec_if

/* File: hw/mon_subcmd_decode.sv */
`timescale 1ns/1ps
`include "ata_cmd_cfg.svh"

module mon_subcmd_decode (
	mon_dec_if.dec bus
);
	// ==========================================
	// subcommand selection from feature byte
	wire is_values = bus.feature == `MON_READ_VALUES;
	wire is_thresh = bus.feature == `MON_READ_THRESH;
	wire is_autosave = bus.feature == `MON_AUTOSAVE;
	wire is_save = bus.feature == `MON_SAVE_VALUES;
	wire is_offline = bus.feature == `MON_OFFLINE_NOW;
	wire is_rd_log = bus.feature == `MON_READ_LOG;
	wire is_wr_log = bus.feature == `MON_WRITE_LOG;
	wire is_enable = bus.feature == `MON_ENABLE;
	wire is_disable = bus.feature == `MON_DISABLE;
	wire is_health = bus.feature == `MON_HEALTH;
	wire is_auto_off = bus.feature == `MON_AUTO_OFFLINE;

	// ==========================================
	// argument checks
	wire key_ok = (bus.cyl_lo == `MON_KEY_LO) && (bus.cyl_hi == `MON_KEY_HI);
	wire autosave_bad = is_autosave && (bus.count != `AUTOSAVE_OFF) && (bus.count != `AUTOSAVE_ON);
	wire log_ext = (bus.sector == `LOG_EXT_ERR) || (bus.sector == `LOG_EXT_TEST);
	wire log_vendor = (bus.sector >= `LOG_VENDOR_LO) && (bus.sector <= `LOG_VENDOR_HI);
	wire log_writable = log_vendor || (bus.sector == `LOG_SELECTIVE);
	wire rd_log_bad = is_rd_log && log_ext;
	wire wr_log_bad = is_wr_log && !log_writable;

	assign bus.op = is_values ? ata_cmd_pkg::MON_OP_READ_VALUES :
		is_thresh ? ata_cmd_pkg::MON_OP_READ_THRESH :
		is_autosave ? ata_cmd_pkg::MON_OP_AUTOSAVE :
		is_save ? ata_cmd_pkg::MON_OP_SAVE_VALUES :
		is_offline ? ata_cmd_pkg::MON_OP_OFFLINE_NOW :
		is_rd_log ? ata_cmd_pkg::MON_OP_READ_LOG :
		is_wr_log ? ata_cmd_pkg::MON_OP_WRITE_LOG :
		is_enable ? ata_cmd_pkg::MON_OP_ENABLE :
		is_disable ? ata_cmd_pkg::MON_OP_DISABLE :
		is_health ? ata_cmd_pkg::MON_OP_HEALTH :
		is_auto_off ? ata_cmd_pkg::MON_OP_AUTO_OFFLINE :
		ata_cmd_pkg::MON_OP_NONE;

	assign bus.abort = !key_ok || (bus.op == ata_cmd_pkg::MON_OP_NONE) || autosave_bad || rd_log_bad
		|| wr_log_bad;
endmodule : mon_subcmd_decode

/* File: tb/ata_cmd_monitor.sv */
`timescale 1ns/1ps
// ==========
// protocol checker
module ata_cmd_monitor #(
	parameter int BLOCK_MAX = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic soft_reset,
	input wire logic media_spun_down,
	input wire logic sector_done,
	input wire logic [7:0] drive_status_byte,
	input wire logic [7:0] command_error_byte,
	input wire logic cmd_complete,
	input wire logic spin_down_req,
	input wire logic sleep_active,
	input wire logic multi_enable,
	input wire logic [4:0] multi_block_size,
	input wire logic block_boundary,
	input wire logic mon_start,
	input wire ata_cmd_pkg::mon_op_e mon_op
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_size_legal:
	assert property (multi_enable |-> multi_block_size inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10}
		&& multi_block_size <= BLOCK_MAX) else $error("illegal block size");
	chk_off_zero:
	assert property (!multi_enable |-> multi_block_size == 5'h00) else $error("size kept while off");
	chk_boundary_cause:
	assert property (block_boundary |-> $past(sector_done) && multi_enable) else $error("stray boundary");
	chk_done_status:
	assert property (cmd_complete |-> drive_status_byte[6] && !drive_status_byte[7]
		&& drive_status_byte[0] == command_error_byte[2]) else $error("bad completion status");
	chk_ready_busy:
	assert property (drive_status_byte[6] != drive_status_byte[7]) else $error("ready equals busy");
	chk_sleep_hold:
	assert property (sleep_active && !soft_reset |=> sleep_active) else $error("sleep left");
	chk_soft_wake:
	assert property (soft_reset |=> !sleep_active && !drive_status_byte[7] && !command_error_byte[2])
		else $error("soft reset ignored");
	chk_sleep_quiet:
	assert property (sleep_active |-> !mon_start && !spin_down_req) else $error("activity in sleep");
	chk_spin_skip:
	assert property (spin_down_req |-> !media_spun_down) else $error("spin down when stopped");
	chk_mon_op:
	assert property (mon_start |-> mon_op != ata_cmd_pkg::MON_OP_NONE && drive_status_byte[7])
		else $error("bad monitor start");
endmodule : ata_cmd_monitor

bind ata_multiple_sleep_smart_cmds ata_cmd_monitor #(.BLOCK_MAX(BLOCK_MAX)) i_ata_cmd_monitor (
	.clock(clock),
	.rst(rst),
	.soft_reset(soft_reset),
	.media_spun_down(media_spun_down),
	.sector_done(sector_done),
	.drive_status_byte(drive_status_byte),
	.command_error_byte(command_error_byte),
	.cmd_complete(cmd_complete),
	.spin_down_req(spin_down_req),
	.sleep_active(sleep_active),
	.multi_enable(multi_enable),
	.multi_block_size(multi_block_size),
	.block_boundary(block_boundary),
	.mon_start(mon_start),
	.mon_op(mon_op)
);

/* File: tb/ata_host_model.sv */
`timescale 1ns/1ps
`include "ata_cmd_cfg.svh"
// ==========
// host task-file writer
module ata_host_model (
	input wire logic clock,
	output logic tf_wr_en,
	output logic [2:0] tf_sel,
	output logic [7:0] tf_wdata
);
	initial begin
		tf_wr_en = 1'b0;
		tf_sel = 3'h0;
		tf_wdata = 8'h00;
	end
	task automatic wr(input logic [2:0] sel, input logic [7:0] data);
		@(negedge clock);
		tf_wr_en = 1'b1;
		tf_sel = sel;
		tf_wdata = data;
		@(negedge clock);
		tf_wr_en = 1'b0;
		tf_wdata = ~data;
	endtask : wr
	task automatic mon(input logic [7:0] sub, cnt, sec, lo, hi);
		wr(`TF_SEL_FEATURE, sub);
		wr(`TF_SEL_COUNT, cnt);
		wr(`TF_SEL_SECTOR, sec);
		wr(`TF_SEL_CYL_LO, lo);
		wr(`TF_SEL_CYL_HI, hi);
		wr(`TF_SEL_COMMAND, `OP_MONITOR);
	endtask : mon
	task automatic set_multi(input logic [7:0] cnt);
		wr(`TF_SEL_COUNT, cnt);
		wr(`TF_SEL_COMMAND, `OP_SET_MULTI);
	endtask : set_multi
endmodule : ata_host_model

/* File: tb/ata_multiple_sleep_smart_cmds_tb.sv */
`timescale 1ns/1ps
`include "ata_cmd_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
`define WAITS(s) begin n = 0; while (!(s) && n < 60) begin @(negedge clock); n++; end `CHK("wait", 1'b1, (s)) end
// ==========
// bench
module ata_multiple_sleep_smart_cmds_tb;
	logic clock, rst, soft_reset, media_spun_down, spin_down_done, multi_xfer_active, sector_done, mon_done, mon_fail;
	wire logic tf_wr_en, cmd_complete, spin_down_req, sleep_active, multi_enable, block_boundary, mon_start;
	wire logic [2:0] tf_sel;
	wire logic [7:0] tf_wdata, drive_status_byte, command_error_byte, mon_count, mon_sector;
	wire logic [4:0] multi_block_size;
	wire ata_cmd_pkg::mon_op_e mon_op;
	int err_total, num_checks, n, hits;
	ata_host_model i_ata_host_model (.clock(clock), .tf_wr_en(tf_wr_en), .tf_sel(tf_sel), .tf_wdata(tf_wdata));
	ata_multiple_sleep_smart_cmds i_ata_multiple_sleep_smart_cmds (.clock(clock), .rst(rst), .soft_reset(soft_reset),
		.tf_wr_en(tf_wr_en), .tf_sel(tf_sel), .tf_wdata(tf_wdata), .media_spun_down(media_spun_down),
		.spin_down_done(spin_down_done), .multi_xfer_active(multi_xfer_active), .sector_done(sector_done),
		.mon_done(mon_done), .mon_fail(mon_fail), .drive_status_byte(drive_status_byte),
		.command_error_byte(command_error_byte), .cmd_complete(cmd_complete), .spin_down_req(spin_down_req),
		.sleep_active(sleep_active), .multi_enable(multi_enable), .multi_block_size(multi_block_size),
		.block_boundary(block_boundary), .mon_start(mon_start), .mon_op(mon_op), .mon_count(mon_count),
		.mon_sector(mon_sector));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic t_multi(input logic [7:0] cnt, input logic ok);
		i_ata_host_model.set_multi(cnt);
		`WAITS(cmd_complete)
		`CHK("enable", 1'(ok && cnt != 8'h00), multi_enable)
		`CHK("size", ok ? cnt[4:0] : 5'h00, multi_block_size)
		`CHK("abort", 1'(!ok), command_error_byte[`ERR_ABT])
		`CHK("status", ok ? 8'h50 : 8'h51, drive_status_byte)
		$display("test multi %h done", cnt);
	endtask : t_multi
	task automatic t_boundary();
		hits = 0;
		multi_xfer_active = 1'b1;
		repeat (8) begin
			@(negedge clock);
			sector_done = 1'b1;
			@(negedge clock);
			sector_done = 1'b0;
			hits += int'(block_boundary);
		end
		multi_xfer_active = 1'b0;
		`CHK("boundaries", 2, hits)
		$display("test boundary done");
	endtask : t_boundary
	task automatic t_sleep(input logic [7:0] op, input logic down);
		media_spun_down = down;
		i_ata_host_model.wr(`TF_SEL_COMMAND, op);
		if (!down) begin
			`WAITS(spin_down_req)
			@(negedge clock);
			spin_down_done = 1'b1;
			@(negedge clock);
			spin_down_done = 1'b0;
		end
		`WAITS(sleep_active)
		i_ata_host_model.set_multi(8'h02);
		repeat (4) @(negedge clock);
		`CHK("asleep", 1'b1, sleep_active)
		`CHK("size", 5'h04, multi_block_size)
		soft_reset = 1'b1;
		@(negedge clock);
		soft_reset = 1'b0;
		`CHK("awake", 1'b0, sleep_active)
		`CHK("status", 8'h50, drive_status_byte)
		$display("test sleep %h done", op);
	endtask : t_sleep
	task automatic t_mon();
		logic [7:0] codes [11] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hdb};
		logic [7:0] cnt, sec;
		logic [23:0] bad [4] = '{24'hd70100, 24'hd20500, 24'hd50103, 24'hd60106};
		for (int i = 0; i < 11; i++) begin
			cnt = (codes[i] == `MON_AUTOSAVE) ? `AUTOSAVE_ON : 8'h01;
			sec = (codes[i] == `MON_READ_LOG) ? 8'h06 : (codes[i] == `MON_WRITE_LOG) ? `LOG_SELECTIVE : 8'h00;
			i_ata_host_model.mon(codes[i], cnt, sec, `MON_KEY_LO, `MON_KEY_HI);
			`WAITS(mon_start)
			`CHK("op", 4'(i + 1), mon_op)
			`CHK("count", cnt, mon_count)
			`CHK("sector", sec, mon_sector)
			mon_done = 1'b1;
			mon_fail = 1'(i == 10);
			@(negedge clock);
			mon_done = 1'b0;
			mon_fail = 1'b0;
			`WAITS(cmd_complete)
			`CHK("abort", 1'(i == 10), command_error_byte[`ERR_ABT])
		end
		i_ata_host_model.mon(`MON_HEALTH, 8'h00, 8'h00, 8'h00, `MON_KEY_HI);
		`WAITS(cmd_complete)
		`CHK("key abort", 8'h04, command_error_byte)
		foreach (bad[i]) begin
			i_ata_host_model.mon(bad[i][23:16], bad[i][15:8], bad[i][7:0], `MON_KEY_LO, `MON_KEY_HI);
			`WAITS(cmd_complete)
			`CHK("no start", 1'b0, mon_start)
			`CHK("arg abort", 8'h51, drive_status_byte)
		end
		i_ata_host_model.wr(`TF_SEL_COMMAND, 8'h00);
		`WAITS(cmd_complete)
		`CHK("opcode abort", 8'h04, command_error_byte)
		$display("test monitor done");
	endtask : t_mon
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#100000;
		err_total++;
		$display("mismatch watchdog expected end seen hang");
		stop_test();
	end
	initial begin
		logic [7:0] sizes [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h11, 8'h20, 8'h04};
		{rst, soft_reset, media_spun_down, spin_down_done, multi_xfer_active, sector_done, mon_done, mon_fail} = 8'h80;
		err_total = 0;
		num_checks = 0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		`CHK("status reset", 8'h50, drive_status_byte)
		`CHK("error reset", 8'h00, command_error_byte)
		foreach (sizes[i]) t_multi(sizes[i], 1'(i < 6 || i == 9));
		t_boundary();
		t_sleep(`OP_SLEEP, 1'b0);
		t_sleep(`OP_SLEEP_ALT, 1'b1);
		t_mon();
		stop_test();
	end
endmodule : ata_multiple_sleep_smart_cmds_tb
